// >>> sbcl_cmd_legality.v
`timescale 1ns/1ps
`include "sbcl_defines.vh"

module sbcl_cmd_legality (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rstn,
   // Command bus pins from the controller
   input  wire        mem_ck,
   input  wire        cke,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [1:0]  ba,
   input  wire        close_select_address_bit,
   // Per-bank state, eight one-hot bits per bank
   output wire [31:0] bank_state,
   output wire [3:0]  bank_ap_access,
   // Command outcome and device status
   output reg         cmd_accept_ff,
   output reg         cmd_illegal_ff,
   output reg         dev_busy_ff,
   output reg         self_refresh_ff,
   output reg  [1:0]  rd_owner_ff
);

   // Header counts are integers; cut to the 8-bit counters on purpose
   localparam integer RFC_I = `SBCL_RFC_CYC;
   localparam integer MRD_I = `SBCL_MRD_CYC;
   localparam integer RP_I  = `SBCL_RP_CYC;
   localparam integer XP_I  = `SBCL_XP_CYC;
   localparam integer XSR_I = `SBCL_XSR_CYC;
   localparam [7:0]   RFC_C = RFC_I[7:0];
   localparam [7:0]   MRD_C = MRD_I[7:0];
   localparam [7:0]   RP_C  = RP_I[7:0];
   localparam [7:0]   XP_C  = XP_I[7:0];
   localparam [7:0]   XSR_C = XSR_I[7:0];

   // Decode strobes into a command code, deselect folded into no-operation
   function [3:0] cmd_decode;
      input [3:0] strobes;
      begin
         cmd_decode = strobes[3] ? `SBCL_CMD_NOP : strobes;
      end
   endfunction

   // Pin synchroniser: {ck, cke, cs_n, ras_n, cas_n, we_n, ba, a10}
   reg  [8:0] sync1_ff;
   reg  [8:0] sync2_ff;
   reg  [8:0] sync3_ff;
   reg        ck_lvl_ff;
   wire [8:0] pins = {mem_ck, cke, cs_n, ras_n, cas_n, we_n, ba, close_select_address_bit};

   always @(posedge core_clk) begin
      if (!rstn) begin
         // Deselect levels with link clock high, so no false edge follows reset
         sync1_ff  <= 9'h178;
         sync2_ff  <= 9'h178;
         sync3_ff  <= 9'h178;
         ck_lvl_ff <= 1'b1;
      end else begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff[8] == sync3_ff[8])
            ck_lvl_ff <= sync3_ff[8];
      end
   end

   // Link rising edge once stages two and three agree on the new level
   wire       ck_rise = (sync2_ff[8] == sync3_ff[8]) && sync3_ff[8] && !ck_lvl_ff;
   wire       s_cke   = sync3_ff[7];
   wire [3:0] cmd     = cmd_decode(sync3_ff[6:3]);
   wire [1:0] s_ba    = sync3_ff[2:1];
   wire       s_a10   = sync3_ff[0];

   // Bank state views
   wire [3:0] b_idle;
   wire [3:0] b_rdy;
   wire [3:0] b_rd;
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1) begin : g_view
         assign b_idle[gb] = bank_state[gb*8 + `SBCL_ST_IDLE];
         assign b_rd[gb]   = bank_state[gb*8 + `SBCL_ST_RD];
         assign b_rdy[gb]  = bank_state[gb*8 + `SBCL_ST_ACTV]
                           | bank_state[gb*8 + `SBCL_ST_RD]
                           | bank_state[gb*8 + `SBCL_ST_WR];
      end
   endgenerate

   reg        cke_prev_ff;
   reg  [7:0] gcnt_ff;
   reg  [7:0] xcnt_ff;
   wire [3:0] tgt    = 4'h1 << s_ba;
   wire       all_idle = &b_idle;
   wire       other_ap = |(bank_ap_access & ~tgt);
   wire       tgt_idle = |(b_idle & tgt);
   wire       tgt_rdy  = |(b_rdy & tgt);
   wire       cmd_ok   = cke_prev_ff && s_cke && (xcnt_ff == 8'h00) && !dev_busy_ff;

   // Legality of the sampled command against current bank states
   reg legal;
   always @* begin
      legal = 1'b0;
      case (cmd)
         `SBCL_CMD_ACT: legal = tgt_idle;
         `SBCL_CMD_RD,
         `SBCL_CMD_WR:  legal = tgt_rdy && !other_ap;
         `SBCL_CMD_PRE: legal = s_a10 ? &(b_idle | b_rdy)
                                      : (tgt_idle || tgt_rdy);
         `SBCL_CMD_REF,
         `SBCL_CMD_MRS: legal = all_idle;
         `SBCL_CMD_BST: legal = |(b_rd & (4'h1 << rd_owner_ff));
         default:       legal = 1'b0;
      endcase
   end

   // Pulses into the banks, one core cycle after the link edge
   reg [3:0] do_act_ff;
   reg [3:0] do_rd_ff;
   reg [3:0] do_wr_ff;
   reg [3:0] do_pre_ff;
   reg [3:0] do_cut_ff;
   reg       do_close_ff;
   reg       ck_rise_ff;
   wire      take = ck_rise && cmd_ok && (cmd != `SBCL_CMD_NOP) && legal;

   always @(posedge core_clk) begin
      if (!rstn) begin
         do_act_ff   <= 4'h0;
         do_rd_ff    <= 4'h0;
         do_wr_ff    <= 4'h0;
         do_pre_ff   <= 4'h0;
         do_cut_ff   <= 4'h0;
         do_close_ff <= 1'b0;
         ck_rise_ff  <= 1'b0;
         rd_owner_ff <= 2'h0;
      end else begin
         ck_rise_ff  <= ck_rise;
         do_close_ff <= s_a10;
         // Illegal commands leave every bank untouched
         do_act_ff   <= (take && cmd == `SBCL_CMD_ACT) ? tgt : 4'h0;
         do_rd_ff    <= (take && cmd == `SBCL_CMD_RD) ? tgt : 4'h0;
         do_wr_ff    <= (take && cmd == `SBCL_CMD_WR) ? tgt : 4'h0;
         do_pre_ff   <= (take && cmd == `SBCL_CMD_PRE) ? (s_a10 ? 4'hf : tgt) : 4'h0;
         // A new burst on one bank ends open bursts elsewhere; terminate hits the owner
         if (take && (cmd == `SBCL_CMD_RD || cmd == `SBCL_CMD_WR))
            do_cut_ff <= ~tgt;
         else if (take && cmd == `SBCL_CMD_BST)
            do_cut_ff <= 4'h1 << rd_owner_ff;
         else
            do_cut_ff <= 4'h0;
         if (take && cmd == `SBCL_CMD_RD)
            rd_owner_ff <= s_ba;
      end
   end

   // Bank trackers
   generate
      for (gb = 0; gb < 4; gb = gb + 1) begin : g_bank
         sbcl_bank u_bank (
            .core_clk     (core_clk),
            .rstn         (rstn),
            .ck_rise      (ck_rise_ff),
            .do_act       (do_act_ff[gb]),
            .do_rd        (do_rd_ff[gb]),
            .do_wr        (do_wr_ff[gb]),
            .do_pre       (do_pre_ff[gb] & ~b_idle[gb]),
            .do_close     (do_close_ff),
            .do_cut       (do_cut_ff[gb]),
            .st_ff        (bank_state[gb*8 +: 8]),
            .ap_access_ff (bank_ap_access[gb])
         );
      end
   endgenerate

   // Device-wide busy windows, clock enable history and exit timing
   always @(posedge core_clk) begin
      if (!rstn) begin
         cke_prev_ff     <= 1'b0;
         gcnt_ff         <= 8'h00;
         dev_busy_ff     <= 1'b0;
         xcnt_ff         <= 8'h00;
         self_refresh_ff <= 1'b0;
         cmd_accept_ff   <= 1'b0;
         cmd_illegal_ff  <= 1'b0;
      end else begin
         cmd_accept_ff  <= take;
         // Deselect and no-operation are never illegal, even while busy
         cmd_illegal_ff <= ck_rise && cke_prev_ff && s_cke
                           && (cmd != `SBCL_CMD_NOP) && !take;
         if (ck_rise)
            cke_prev_ff <= s_cke;
         if (ck_rise && cke_prev_ff && !s_cke && cmd == `SBCL_CMD_REF && all_idle)
            self_refresh_ff <= 1'b1;
         if (ck_rise && !cke_prev_ff && s_cke) begin
            // Exit wait counted in core cycles from the first high edge
            xcnt_ff         <= self_refresh_ff ? XSR_C : XP_C;
            self_refresh_ff <= 1'b0;
         end else if (xcnt_ff != 8'h00) begin
            xcnt_ff <= xcnt_ff - 8'h01;
         end
         if (take && cmd == `SBCL_CMD_REF) begin
            gcnt_ff     <= RFC_C;
            dev_busy_ff <= 1'b1;
         end else if (take && cmd == `SBCL_CMD_MRS) begin
            gcnt_ff     <= MRD_C;
            dev_busy_ff <= 1'b1;
         end else if (take && cmd == `SBCL_CMD_PRE && s_a10) begin
            gcnt_ff     <= RP_C;
            dev_busy_ff <= 1'b1;
         end else if (gcnt_ff > 8'h01) begin
            gcnt_ff <= gcnt_ff - 8'h01;
         end else begin
            gcnt_ff     <= 8'h00;
            dev_busy_ff <= 1'b0;
         end
      end
   end

endmodule // sbcl_cmd_legality

// >>> sbcl_defines.vh
`ifndef SBCL_DEFINES_VH
`define SBCL_DEFINES_VH

// Core clock rate
`define SBCL_CLK_MHZ        100

// Array timings in ns (least times)
`define SBCL_ROW_PRECHARGE_TIME_NS       18
`define SBCL_ACTIVATE_TO_ACCESS_DELAY_NS 18
`define SBCL_REFRESH_CYCLE_TIME_NS       72
`define SBCL_MODE_LOAD_DELAY_NS          10
`define SBCL_WRITE_RECOVERY_TIME_NS      15
`define SBCL_POWERDOWN_EXIT_TIME_NS      25
`define SBCL_SELF_REFRESH_EXIT_TIME_NS   112

// Same timings in core cycles, rounded up
`define SBCL_NS2CYC(ns)     (((ns) * `SBCL_CLK_MHZ + 999) / 1000)
`define SBCL_RP_CYC         `SBCL_NS2CYC(`SBCL_ROW_PRECHARGE_TIME_NS)
`define SBCL_RCD_CYC        `SBCL_NS2CYC(`SBCL_ACTIVATE_TO_ACCESS_DELAY_NS)
`define SBCL_RFC_CYC        `SBCL_NS2CYC(`SBCL_REFRESH_CYCLE_TIME_NS)
`define SBCL_MRD_CYC        `SBCL_NS2CYC(`SBCL_MODE_LOAD_DELAY_NS)
`define SBCL_WR_CYC         `SBCL_NS2CYC(`SBCL_WRITE_RECOVERY_TIME_NS)
`define SBCL_XP_CYC         `SBCL_NS2CYC(`SBCL_POWERDOWN_EXIT_TIME_NS)
`define SBCL_XSR_CYC        `SBCL_NS2CYC(`SBCL_SELF_REFRESH_EXIT_TIME_NS)

// Burst length in link clock edges (burst of four, two data pairs)
`define SBCL_RD_BURST_EDGES 2
// Write data ends one edge later than read data (write strobe latency)
`define SBCL_WR_BURST_EDGES 3

// Bank state vector bit positions (one-hot)
`define SBCL_ST_IDLE        0
`define SBCL_ST_ACTG        1
`define SBCL_ST_ACTV        2
`define SBCL_ST_RD          3
`define SBCL_ST_WR          4
`define SBCL_ST_RDAC        5
`define SBCL_ST_WRAC        6
`define SBCL_ST_PRE         7
`define SBCL_ST_W           8

// Command codes {cs_n, ras_n, cas_n, we_n} with chip select low
`define SBCL_CMD_NOP        4'h7
`define SBCL_CMD_ACT        4'h3
`define SBCL_CMD_RD         4'h5
`define SBCL_CMD_WR         4'h4
`define SBCL_CMD_BST        4'h6
`define SBCL_CMD_PRE        4'h2
`define SBCL_CMD_REF        4'h1
`define SBCL_CMD_MRS        4'h0

`endif

// >>> sbcl_bank.v
`timescale 1ns/1ps
`include "sbcl_defines.vh"

module sbcl_bank (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rstn,
   // Link edge and accepted commands for this bank
   input  wire       ck_rise,
   input  wire       do_act,
   input  wire       do_rd,
   input  wire       do_wr,
   input  wire       do_pre,
   input  wire       do_close,
   input  wire       do_cut,
   // Bank state
   output reg  [7:0] st_ff,
   output reg        ap_access_ff
);

   localparam [7:0] IDLE = 8'h01;
   localparam [7:0] ACTG = 8'h02;
   localparam [7:0] ACTV = 8'h04;
   localparam [7:0] RD   = 8'h08;
   localparam [7:0] WR   = 8'h10;
   localparam [7:0] RDAC = 8'h20;
   localparam [7:0] WRAC = 8'h40;
   localparam [7:0] PRE  = 8'h80;

   // Header counts are integers; cut to the counter widths on purpose
   localparam integer RP_I  = `SBCL_RP_CYC;
   localparam integer RCD_I = `SBCL_RCD_CYC;
   localparam integer WR_I  = `SBCL_WR_CYC;
   localparam integer RD_EI = `SBCL_RD_BURST_EDGES;
   localparam integer WR_EI = `SBCL_WR_BURST_EDGES;
   localparam [7:0]   RP_C  = RP_I[7:0];
   localparam [7:0]   RCD_C = RCD_I[7:0];
   localparam [7:0]   WR_C  = WR_I[7:0];
   localparam [3:0]   RD_E  = RD_EI[3:0];
   localparam [3:0]   WR_E  = WR_EI[3:0];

   reg [7:0] tcnt_ff;
   reg [3:0] bcnt_ff;
   reg       wrec_ff;
   reg [7:0] nxt_st;
   reg [7:0] nxt_tcnt;
   reg [3:0] nxt_bcnt;
   reg       nxt_wrec;
   reg       nxt_ap_access;

   // Next state; the top raises do_act, do_rd, do_wr and do_pre only where accepted; do_cut (other banks, or the owner on terminate) acts only in RD or WR
   always @* begin
      nxt_st        = st_ff;
      nxt_tcnt      = tcnt_ff;
      nxt_bcnt      = bcnt_ff;
      nxt_wrec      = wrec_ff;
      nxt_ap_access = ap_access_ff;
      case (st_ff)
         IDLE: begin
            if (do_act) begin
               nxt_st   = ACTG;
               nxt_tcnt = RCD_C - 8'h01;
            end
         end
         ACTG: begin
            if (tcnt_ff == 8'h00)
               nxt_st = ACTV;
            else
               nxt_tcnt = tcnt_ff - 8'h01;
         end
         ACTV, RD, WR: begin
            if (do_rd || do_wr) begin
               // Either flavour of burst is honoured per command
               nxt_st        = do_rd ? (do_close ? RDAC : RD)
                                     : (do_close ? WRAC : WR);
               nxt_bcnt      = do_rd ? RD_E : WR_E;
               nxt_ap_access = do_close;
               nxt_wrec      = 1'b0;
            end else if (do_pre) begin
               nxt_st   = PRE;
               nxt_tcnt = RP_C - 8'h01;
            end else if (st_ff != ACTV && do_cut) begin
               nxt_st = ACTV;
            end else if (st_ff != ACTV && ck_rise) begin
               if (bcnt_ff == 4'h1)
                  nxt_st = ACTV;
               nxt_bcnt = bcnt_ff - 4'h1;
            end
         end
         RDAC, WRAC: begin
            if (ap_access_ff) begin
               // Access period runs in link edges
               if (ck_rise) begin
                  nxt_bcnt = bcnt_ff - 4'h1;
                  if (bcnt_ff == 4'h1) begin
                     nxt_ap_access = 1'b0;
                     nxt_wrec      = (st_ff == WRAC);
                     nxt_tcnt      = (st_ff == WRAC) ? WR_C - 8'h01 : RP_C - 8'h01;
                  end
               end
            end else if (tcnt_ff != 8'h00) begin
               nxt_tcnt = tcnt_ff - 8'h01;
            end else if (wrec_ff) begin
               // Write recovery over; precharge period starts now
               nxt_wrec = 1'b0;
               nxt_tcnt = RP_C - 8'h01;
            end else begin
               nxt_st = IDLE;
            end
         end
         PRE: begin
            if (tcnt_ff == 8'h00)
               nxt_st = IDLE;
            else
               nxt_tcnt = tcnt_ff - 8'h01;
         end
         default: begin
            nxt_st = IDLE;
         end
      endcase
   end

   // State registers
   always @(posedge core_clk) begin
      if (!rstn) begin
         st_ff        <= IDLE;
         tcnt_ff      <= 8'h00;
         bcnt_ff      <= 4'h0;
         wrec_ff      <= 1'b0;
         ap_access_ff <= 1'b0;
      end else begin
         st_ff        <= nxt_st;
         tcnt_ff      <= nxt_tcnt;
         bcnt_ff      <= nxt_bcnt;
         wrec_ff      <= nxt_wrec;
         ap_access_ff <= nxt_ap_access;
      end
   end

endmodule // sbcl_bank

// >>> sbcl_checker.sv
`timescale 1ns/1ps

module sbcl_checker (
   // Clock and reset
   input wire        core_clk,
   input wire        rstn,
   // Watched outputs
   input wire [31:0] bank_state,
   input wire [3:0]  bank_ap_access,
   input wire        cmd_accept_ff,
   input wire        cmd_illegal_ff,
   input wire        dev_busy_ff
);
   // One clock domain, so one default for all checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_flag_exclusive: assert property (!(cmd_accept_ff && cmd_illegal_ff))
      else $error("accept and refuse in one cycle");
   a_banks_onehot: assert property ($onehot(bank_state[7:0]) && $onehot(bank_state[15:8])
      && $onehot(bank_state[23:16]) && $onehot(bank_state[31:24]))
      else $error("bank state not one-hot");
   a_idle_needs_accept: assert property (bank_state[0] && !cmd_accept_ff |=> bank_state[0])
      else $error("idle bank left without a command");
   a_activate_time: assert property ($rose(bank_state[1]) |-> ##1 bank_state[1] ##1 bank_state[2])
      else $error("activating period wrong");
   a_precharge_time: assert property ($rose(bank_state[7]) |-> ##1 bank_state[7] ##1 bank_state[0])
      else $error("precharging period wrong");
   a_busy_blocks: assert property (dev_busy_ff && $past(dev_busy_ff) |-> !cmd_accept_ff)
      else $error("command taken while busy");
   a_busy_bounded: assert property ($rose(dev_busy_ff) |-> ##[1:8] !dev_busy_ff)
      else $error("busy window too long");
   a_busy_end_idle: assert property ($fell(dev_busy_ff) |-> ##[0:2] (bank_state == 32'h01010101))
      else $error("banks not idle after busy window");
   a_access_in_close: assert property (bank_ap_access[1] |-> bank_state[13] || bank_state[14])
      else $error("access period outside a closing burst");

   // Main scenarios reached
   c_activate: cover property ($rose(bank_state[1]));
   c_busy: cover property ($rose(dev_busy_ff));
   c_refused: cover property (cmd_illegal_ff);
   c_close_access: cover property (bank_ap_access[1]);
endmodule // sbcl_checker

bind sbcl_cmd_legality sbcl_checker sbcl_checker_inst (.core_clk(core_clk), .rstn(rstn),
   .bank_state(bank_state), .bank_ap_access(bank_ap_access), .cmd_accept_ff(cmd_accept_ff),
   .cmd_illegal_ff(cmd_illegal_ff), .dev_busy_ff(dev_busy_ff));

// >>> sbcl_ctrl_model.sv
`timescale 1ns/1ps

module sbcl_ctrl_model (
   // Link clock and clock enable
   output reg       mem_ck,
   output reg       cke,
   // Command strobes and address
   output reg       cs_n,
   output reg       ras_n,
   output reg       cas_n,
   output reg       we_n,
   output reg [1:0] ba,
   output reg       close_select_address_bit
);
   // Memory clock runs free; first edge offset from the core clock
   initial begin
      mem_ck = 1'b0;
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      ba = 2'h0;
      close_select_address_bit = 1'b0;
      #3;
      forever #62.5 mem_ck = ~mem_ck;
   end

   // Drive at a falling edge, hold through the next rise; caller sits on a falling edge
   // Sequencer sends busy banks only no-operations
   // Terminate only plain reads, writes after read end
   // Reads never cut a write, so no write data ever needs masking
   // During an access period other banks get only activate or precharge,
   // apart from one deliberate refusal case
   task issue(input [3:0] c, input [1:0] b, input a);
      begin
         {cs_n, ras_n, cas_n, we_n} <= c;
         ba <= (c == 4'h7) ? ~ba : b; // Don't-care lines keep moving
         close_select_address_bit <= (c == 4'h7) ? ~close_select_address_bit : a;
         @(negedge mem_ck);
      end
   endtask

   // Clock enable changes only between rises
   task set_cke(input v);
      cke <= v;
   endtask
endmodule // sbcl_ctrl_model

// >>> sdram_bank_command_legality_tb_top.sv
`timescale 1ns/1ps
`include "sbcl_defines.vh"

module sdram_bank_command_legality_tb_top;
   // Clocks, pins and outputs
   reg         core_clk;
   reg         rstn;
   wire        mem_ck, cke, cs_n, ras_n, cas_n, we_n, close_select_address_bit;
   wire [1:0]  ba, rd_owner_ff;
   wire [31:0] bank_state;
   wire [3:0]  bank_ap_access;
   wire        cmd_accept_ff, cmd_illegal_ff, dev_busy_ff, self_refresh_ff;
   integer     errors = 0, n_tests = 0, n_acc = 0, n_ill = 0, cyc = 0, got;

   sbcl_cmd_legality sbcl_cmd_legality_inst (.core_clk(core_clk), .rstn(rstn), .mem_ck(mem_ck),
      .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .close_select_address_bit(close_select_address_bit), .bank_state(bank_state),
      .bank_ap_access(bank_ap_access), .cmd_accept_ff(cmd_accept_ff),
      .cmd_illegal_ff(cmd_illegal_ff), .dev_busy_ff(dev_busy_ff),
      .self_refresh_ff(self_refresh_ff), .rd_owner_ff(rd_owner_ff));
   sbcl_ctrl_model sbcl_ctrl_model_inst (.mem_ck(mem_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .close_select_address_bit(close_select_address_bit));

   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Outcome pulses last one cycle, so count them as they pass; also the hang limit
   always @(posedge core_clk) begin
      n_acc = n_acc + (cmd_accept_ff === 1'b1);
      n_ill = n_ill + (cmd_illegal_ff === 1'b1);
      cyc = cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         give_verdict;
      end
   end

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   function [31:0] bst(input integer b);
      bst = (bank_state >> (8 * b)) & 32'hff;
   endfunction

   // One command per link rise; exp is 2 for taken, 1 for refused, 0 for neither
   task cmd(input [3:0] c, input [1:0] b, input a, input [31:0] exp);
      integer a0, i0;
      begin
         a0 = n_acc;
         i0 = n_ill;
         sbcl_ctrl_model_inst.issue(c, b, a);
         got = (n_acc - a0) * 2 + (n_ill - i0);
         chk(got, exp);
      end
   endtask

   task idle(input integer n);
      repeat (n) cmd(`SBCL_CMD_NOP, 2'h0, 1'b0, 32'h0);
   endtask

   task t_reset;
      begin
         chk(bank_state, 32'h01010101);
         chk({cmd_accept_ff, cmd_illegal_ff, dev_busy_ff, self_refresh_ff, rd_owner_ff}, 0);
         $display("test reset done");
      end
   endtask

   task t_open;
      begin
         cmd(4'h8, 2'h0, 1'b0, 32'h0);
         cmd(`SBCL_CMD_ACT, 2'h0, 1'b0, 32'h2);
         cmd(`SBCL_CMD_ACT, 2'h3, 1'b0, 32'h2);
         chk(bst(0), 32'h04);
         cmd(`SBCL_CMD_ACT, 2'h0, 1'b0, 32'h1);
         cmd(`SBCL_CMD_RD, 2'h0, 1'b0, 32'h2);
         chk(bst(0), 32'h08);
         cmd(`SBCL_CMD_RD, 2'h3, 1'b0, 32'h2);
         chk({30'h0, rd_owner_ff}, 32'h3);
         cmd(`SBCL_CMD_BST, 2'h0, 1'b0, 32'h2);
         chk(bst(3), 32'h04);
         cmd(`SBCL_CMD_BST, 2'h0, 1'b0, 32'h1);
         cmd(`SBCL_CMD_WR, 2'h0, 1'b0, 32'h2);
         chk(bst(0), 32'h10);
         idle(3);
         chk(bst(0), 32'h04);
         $display("test open rows done");
      end
   endtask

   task t_close;
      begin
         cmd(`SBCL_CMD_PRE, 2'h0, 1'b0, 32'h2);
         idle(1);
         chk(bst(0), 32'h01);
         cmd(`SBCL_CMD_ACT, 2'h1, 1'b0, 32'h2);
         idle(1);
         cmd(`SBCL_CMD_RD, 2'h1, 1'b1, 32'h2);
         chk(bst(1), 32'h20);
         chk({28'h0, bank_ap_access}, 32'h2);
         cmd(`SBCL_CMD_RD, 2'h3, 1'b0, 32'h1);
         cmd(`SBCL_CMD_ACT, 2'h2, 1'b0, 32'h2);
         idle(2);
         chk(bst(1), 32'h01);
         cmd(`SBCL_CMD_WR, 2'h2, 1'b1, 32'h2);
         chk(bst(2), 32'h40);
         idle(4);
         chk(bst(2), 32'h01);
         $display("test auto close done");
      end
   endtask

   task t_device;
      begin
         cmd(`SBCL_CMD_REF, 2'h0, 1'b0, 32'h1);
         cmd(`SBCL_CMD_MRS, 2'h0, 1'b0, 32'h1);
         cmd(`SBCL_CMD_PRE, 2'h0, 1'b1, 32'h2);
         idle(1);
         chk(bank_state, 32'h01010101);
         cmd(`SBCL_CMD_REF, 2'h0, 1'b0, 32'h2);
         chk({31'h0, dev_busy_ff}, 32'h1);
         cmd(`SBCL_CMD_MRS, 2'h0, 1'b0, 32'h2);
         idle(1);
         chk(bank_state, 32'h01010101);
         $display("test device wide done");
      end
   endtask

   task t_cke;
      begin
         sbcl_ctrl_model_inst.set_cke(1'b0);
         cmd(`SBCL_CMD_REF, 2'h0, 1'b0, 32'h0);
         chk({31'h0, self_refresh_ff}, 32'h1);
         cmd(`SBCL_CMD_ACT, 2'h1, 1'b0, 32'h0);
         chk(bst(1), 32'h01);
         sbcl_ctrl_model_inst.set_cke(1'b1);
         cmd(`SBCL_CMD_ACT, 2'h1, 1'b0, 32'h0);
         chk({31'h0, self_refresh_ff}, 32'h0);
         chk(bst(1), 32'h01);
         idle(1);
         cmd(`SBCL_CMD_ACT, 2'h1, 1'b0, 32'h2);
         chk({31'h0, self_refresh_ff}, 32'h0);
         $display("test clock enable done");
      end
   endtask

   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // Main sequence: hold reset 10 cycles, let the link settle, then the tests
   initial begin
      rstn = 1'b0;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      #1;
      t_reset;
      @(negedge mem_ck);
      idle(3);
      t_open;
      t_close;
      t_device;
      t_cke;
      give_verdict;
   end
endmodule // sdram_bank_command_legality_tb_top
